// *** fsp_defines.svh ***
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH
// Overview of operation
// (RL1) Paused flag, status bit 15, sets after suspend instruction 75h.
// (RL2) Paused flag clears on resume instruction 7Ah and on power cycle.
// (RL3) Three OTP lock bits S13..S11 reset to 0, each settable by status write.
// (RL4) A set lock bit stays 1; its 256-byte security register becomes read-only.
// (RL5) Quad enable 0: hold function active, standard and dual modes only.
// (RL6) Quad enable 1: lines three and four carry data, no hold, quad allowed.
// (RL7) Scheme select 0: protection from complement, granularity, top/bottom, range code.
// (RL8) Scheme select 1: protection only from individual sector and block locks.
// (RL9) Every individual lock bit is 1 after power-on and after reset.
// (RL10) Two-bit strength field picks 100, 75, 50 or 25 percent drive.
// (RL11) Reserved status bits carry no meaning; writes to them do nothing.
// (RL12) Coarse codes 1..6 protect 256KB doubling to 8MB; 0 none, 7 all.
// (RL13) Fine codes 1,2,3,4-5 protect 4KB, 8KB, 16KB, 32KB top or bottom.
// (RL14) Erase or program touching any protected byte is ignored entirely.
// (RL15) Complement bit inverts the selected protected area.
// (RL16) Individual scheme: lock 0 allows erase/program, lock 1 ignores it.
// (RL17) Reserved bits read as 0 and never change on writes.
// (RL18) Protection is decided from current bits when each operation starts.

// ==========================================================
// Instruction codes and register selects
`define FSP_CODE_SUSPEND 8'h75
`define FSP_CODE_RESUME 8'h7a
`define FSP_SEL_SR1 2'h1
`define FSP_SEL_SR2 2'h2
`define FSP_SEL_SR3 2'h3

// ==========================================================
// Field positions
`define FSP_SR1_BP_LSB 2
`define FSP_SR1_TB 5
`define FSP_SR1_SEC 6
`define FSP_SR2_QE 1
`define FSP_SR2_LB1 3
`define FSP_SR2_CMP 6
`define FSP_SR2_SUS 7
`define FSP_SR3_WPS 2
`define FSP_SR3_DRV_LSB 5

// ==========================================================
// Reset values
`define FSP_PROT_RST 6'h00
`define FSP_LB_RST 3'h0
`define FSP_QE_RST 1'h0
`define FSP_WPS_RST 1'h0
`define FSP_DRV_RST 2'h0
`define FSP_LOCK_RST 1'h1

// ==========================================================
// Address width, sizes as address shifts, and sector and block counts
`define FSP_ADDR_W 24
`define FSP_SH_PAGE 5'h08
`define FSP_SH_4K 5'h0c
`define FSP_SH_32K 5'h0f
`define FSP_SH_64K 5'h10
`define FSP_SH_256K 5'h12
`define FSP_SH_CHIP 5'h18
`define FSP_EDGE_SECTORS 16
`define FSP_BLOCKS 256
`endif

// *** fsp_pkg.sv ***
package fsp_pkg;
`include "fsp_defines.svh"

  // Array operation kinds, sized by the region they cover
  typedef enum logic [2:0] {
    fsp_k_page = 3'h0,
    fsp_k_sec = 3'h1,
    fsp_k_b32 = 3'h2,
    fsp_k_b64 = 3'h3,
    fsp_k_chip = 3'h4
  } fsp_kind_t;

  typedef struct packed {
    fsp_kind_t kind;
    logic [`FSP_ADDR_W-1:0] addr;
  } fsp_op_t;

  typedef struct packed {
    logic cmp;
    logic sec;
    logic tb;
    logic [2:0] bp;
  } fsp_prot_t;

  typedef struct packed {
    logic none;
    logic [`FSP_ADDR_W-1:0] lo;
    logic [`FSP_ADDR_W-1:0] hi;
  } fsp_range_t;

  typedef enum logic [1:0] {
    fsp_idle = 2'h1,
    fsp_eval = 2'h2
  } fsp_state_t;
endpackage : fsp_pkg

// *** fsp_range_decode.sv ***
`timescale 1ns/1ns
module fsp_range_decode
  import fsp_pkg::*;
(
  input wire fsp_prot_t prot,
  output fsp_range_t rng
);
  logic [4:0] shift_amt;
  logic [24:0] size_full;
  logic [23:0] size_m1;
  logic all_w;
  logic none_w;

  // ==========================================================
  // Size of the non-complemented range
  // Fine steps 4KB..16KB, codes 10x give 32KB
  assign shift_amt = prot.sec ?
    (prot.bp[2] ? `FSP_SH_32K : `FSP_SH_4K + {3'h0, prot.bp[1:0]} - 5'h01) :
    (`FSP_SH_256K + {2'h0, prot.bp} - 5'h01); // [RL12] [RL13]
  assign size_full = (25'h0000001 << shift_amt) - 25'h0000001;
  assign size_m1 = size_full[23:0];
  assign all_w = (prot.bp == 3'h7); // [RL12]
  assign none_w = (prot.bp == 3'h0); // [RL12]

  // ==========================================================
  // Top ranges end at the last byte, bottom ranges start at zero
  assign rng.none = none_w;
  assign rng.lo = (all_w || prot.tb) ? 24'h000000 : ~size_m1; // [RL12] [RL13]
  assign rng.hi = (all_w || !prot.tb) ? 24'hffffff : size_m1; // [RL12] [RL13]
endmodule : fsp_range_decode

// *** fsp_status_protect.sv ***
`timescale 1ns/1ns
module fsp_status_protect
  import fsp_pkg::*;
#(
  parameter int BLOCKS = `FSP_BLOCKS,
  parameter int EDGE = `FSP_EDGE_SECTORS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [7:0] instr_code,
  input wire logic sw_valid,
  input wire logic [1:0] sw_sel,
  input wire logic [7:0] sw_data,
  input wire logic rd_valid,
  input wire logic [1:0] rd_sel,
  output logic [7:0] rd_data,
  input wire logic op_valid,
  input wire fsp_op_t op_req,
  output logic op_busy,
  output logic op_grant,
  output logic op_deny,
  input wire logic secreg_valid,
  input wire logic [1:0] secreg_num,
  output logic secreg_grant,
  output logic secreg_deny,
  input wire logic blk_lock_valid,
  input wire logic blk_lock_set,
  input wire logic [23:0] blk_lock_addr,
  output logic paused_op_flag,
  output logic quad_lines_enable,
  output logic hold_fn_enable,
  output logic protect_scheme_select,
  output logic [1:0] output_strength
);
  localparam int NENT = 2 * EDGE + BLOCKS - 2;

  // ==========================================================
  // Status state
  logic sus_q;
  logic [2:0] lb_q;
  logic [2:0] lb_d;
  logic qe_q;
  logic hold_q;
  logic wps_q;
  logic [1:0] drv_q;
  fsp_prot_t prot_q;
  fsp_prot_t prot_d;
  logic [7:0] rd_q;
  logic [7:0] rd_d;
  logic [7:0] sr1_w;
  logic [7:0] sr2_w;
  logic [7:0] sr3_w;
  logic wr1_w;
  logic wr2_w;
  logic wr3_w;
  logic susp_w;
  logic resume_w;

  assign susp_w = instr_valid && (instr_code == `FSP_CODE_SUSPEND);
  assign resume_w = instr_valid && (instr_code == `FSP_CODE_RESUME);
  assign wr1_w = sw_valid && (sw_sel == `FSP_SEL_SR1);
  assign wr2_w = sw_valid && (sw_sel == `FSP_SEL_SR2);
  assign wr3_w = sw_valid && (sw_sel == `FSP_SEL_SR3);

  // Lock bits only ever accumulate ones
  assign lb_d = wr2_w ? (lb_q | sw_data[`FSP_SR2_LB1 +: 3]) : lb_q; // [RL3] [RL4]
  assign prot_d = wr1_w ? fsp_prot_t'{cmp: prot_q.cmp, sec: sw_data[`FSP_SR1_SEC],
                            tb: sw_data[`FSP_SR1_TB], bp: sw_data[`FSP_SR1_BP_LSB +: 3]} :
                  wr2_w ? fsp_prot_t'{cmp: sw_data[`FSP_SR2_CMP], sec: prot_q.sec,
                            tb: prot_q.tb, bp: prot_q.bp} : prot_q;

  // Read images; bits this block does not own read as zero
  assign sr1_w = {1'b0, prot_q.sec, prot_q.tb, prot_q.bp, 2'h0}; // [RL17]
  assign sr2_w = {sus_q, prot_q.cmp, lb_q, 1'b0, qe_q, 1'b0}; // [RL17] [RL11]
  assign sr3_w = {1'b0, drv_q, 2'h0, wps_q, 2'h0}; // [RL17] [RL11]
  assign rd_d = !rd_valid ? rd_q :
                (rd_sel == `FSP_SEL_SR1) ? sr1_w :
                (rd_sel == `FSP_SEL_SR2) ? sr2_w :
                (rd_sel == `FSP_SEL_SR3) ? sr3_w : 8'h00;

  // Suspend flag; reset stands for the power cycle, suspend wins a tie
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sus_q <= 1'b0; // [RL2]
    end else if (susp_w) begin
      sus_q <= 1'b1; // [RL1]
    end else if (resume_w) begin
      sus_q <= 1'b0; // [RL2]
    end
  end

  // Configuration bits; reserved positions are never stored
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lb_q <= `FSP_LB_RST;
      prot_q <= `FSP_PROT_RST;
      qe_q <= `FSP_QE_RST;
      hold_q <= 1'b1;
      wps_q <= `FSP_WPS_RST;
      drv_q <= `FSP_DRV_RST;
      rd_q <= 8'h00;
    end else begin
      lb_q <= lb_d;
      prot_q <= prot_d;
      qe_q <= wr2_w ? sw_data[`FSP_SR2_QE] : qe_q;
      hold_q <= wr2_w ? !sw_data[`FSP_SR2_QE] : hold_q; // [RL5] [RL6]
      wps_q <= wr3_w ? sw_data[`FSP_SR3_WPS] : wps_q;
      drv_q <= wr3_w ? sw_data[`FSP_SR3_DRV_LSB +: 2] : drv_q; // [RL10]
      rd_q <= rd_d;
    end
  end

  assign paused_op_flag = sus_q;
  assign quad_lines_enable = qe_q; // [RL6]
  assign hold_fn_enable = hold_q; // [RL5]
  assign protect_scheme_select = wps_q;
  assign output_strength = drv_q; // [RL10]
  assign rd_data = rd_q;

  // ==========================================================
  // Security register guard
  logic sec_grant_q;
  logic sec_deny_q;
  logic sec_locked_w;

  // Register numbers 1..3 map onto lock bits; 0 is not a register
  assign sec_locked_w = (secreg_num == 2'h0) || lb_q[secreg_num - 2'h1]; // [RL4]

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sec_grant_q <= 1'b0;
      sec_deny_q <= 1'b0;
    end else begin
      sec_grant_q <= secreg_valid && !sec_locked_w;
      sec_deny_q <= secreg_valid && sec_locked_w; // [RL4]
    end
  end

  assign secreg_grant = sec_grant_q;
  assign secreg_deny = sec_deny_q;

  // ==========================================================
  // Operation sequencer
  fsp_state_t state_q;
  fsp_state_t state_d;
  fsp_op_t req_q;
  logic grant_q;
  logic deny_q;
  logic busy_q;
  logic [4:0] op_sh_w;
  logic [24:0] op_full_w;
  logic [23:0] op_mask_w;
  logic [23:0] rs_w;
  logic [23:0] re_w;
  fsp_range_t rng_w;
  logic inside_w;
  logic overlap_w;
  logic prot_hit_w;
  logic lock_any_w;
  logic hit_w;
  logic [NENT-1:0] lock_q;
  logic [NENT-1:0] lock_hit_w;

  fsp_range_decode u_range (
    .prot(prot_q),
    .rng(rng_w)
  );

  // Region covered by the held request, aligned to its size
  assign op_sh_w = (req_q.kind == fsp_k_page) ? `FSP_SH_PAGE :
                   (req_q.kind == fsp_k_sec) ? `FSP_SH_4K :
                   (req_q.kind == fsp_k_b32) ? `FSP_SH_32K :
                   (req_q.kind == fsp_k_b64) ? `FSP_SH_64K : `FSP_SH_CHIP;
  assign op_full_w = (25'h0000001 << op_sh_w) - 25'h0000001;
  assign op_mask_w = op_full_w[23:0];
  assign rs_w = req_q.addr & ~op_mask_w;
  assign re_w = req_q.addr | op_mask_w;

  // Any overlap with protection blocks the whole operation
  assign inside_w = !rng_w.none && (rs_w >= rng_w.lo) && (re_w <= rng_w.hi);
  assign overlap_w = !rng_w.none && (rs_w <= rng_w.hi) && (re_w >= rng_w.lo); // [RL14]
  assign prot_hit_w = prot_q.cmp ? !inside_w : overlap_w; // [RL15] [RL14]
  assign lock_any_w = |lock_hit_w; // [RL16]
  assign hit_w = wps_q ? lock_any_w : prot_hit_w; // [RL7] [RL8]

  // Take a request in idle, decide in the next cycle from live bits
  always_comb begin
    state_d = state_q;
    case (state_q)
      fsp_idle: begin
        if (op_valid) begin
          state_d = fsp_eval;
        end
      end
      fsp_eval: begin
        state_d = fsp_idle; // [RL18]
      end
      default: begin
        state_d = fsp_idle;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= fsp_idle;
      req_q <= '0;
      grant_q <= 1'b0;
      deny_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= (state_q == fsp_idle && op_valid) ? op_req : req_q;
      grant_q <= (state_q == fsp_eval) && !hit_w; // [RL18]
      deny_q <= (state_q == fsp_eval) && hit_w; // [RL14]
      busy_q <= (state_d == fsp_eval);
    end
  end

  // Busy mirrors the deciding state from its own flop, so the pin is glitch free
  assign op_busy = busy_q;
  assign op_grant = grant_q;
  assign op_deny = deny_q;

  // ==========================================================
  // Individual locks: edge sectors of first and last block, then inner blocks
  // Costs two comparator pairs per entry, traded for single-cycle decisions
  genvar e;
  generate
    for (e = 0; e < NENT; e++) begin : g_lock
      localparam int LO_I = (e < EDGE) ? (e << 12) :
                            (e < 2 * EDGE) ? (((BLOCKS - 1) << 16) + ((e - EDGE) << 12)) :
                            ((e - 2 * EDGE + 1) << 16);
      localparam int SZ_I = (e < 2 * EDGE) ? 4096 : 65536;
      localparam logic [23:0] E_LO = 24'(LO_I);
      localparam logic [23:0] E_HI = 24'(LO_I + SZ_I - 1);
      logic sel_w;
      logic lk_q;

      assign sel_w = blk_lock_valid && (blk_lock_addr >= E_LO) && (blk_lock_addr <= E_HI);
      assign lock_hit_w[e] = lock_q[e] && (rs_w <= E_HI) && (re_w >= E_LO); // [RL16]
      assign lock_q[e] = lk_q;

      // One flop per entry keeps every lock bit with a single driver
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          lk_q <= `FSP_LOCK_RST; // [RL9]
        end else if (sel_w) begin
          lk_q <= blk_lock_set;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_op_taken;
    (state_q == fsp_idle) && op_valid;
  endsequence

  sequence s_op_done;
    (state_q == fsp_eval) ##1 (op_grant ^ op_deny);
  endsequence

  AST_SUSP_SET: assert property (susp_w |=> paused_op_flag) // [RL1]
    else $error("paused flag not set after suspend");

  AST_SUSP_CLR: assert property (resume_w && !susp_w |=> !paused_op_flag) // [RL2]
    else $error("paused flag not cleared after resume");

  AST_OTP_STICKY: assert property ($past(lb_q) != 3'h0 |-> ((lb_q & $past(lb_q)) == $past(lb_q))) // [RL4]
    else $error("security lock bit returned to zero");

  AST_OTP_SET: assert property (wr2_w && sw_data[`FSP_SR2_LB1] |=> lb_q[0]) // [RL3]
    else $error("security lock bit not set by status write");

  AST_SECREG_DENY: assert property (secreg_valid && secreg_num == 2'h1 && lb_q[0]
                                    |=> secreg_deny && !secreg_grant) // [RL4]
    else $error("locked security register not refused");

  AST_HOLD_QUAD: assert property (hold_fn_enable == !quad_lines_enable) // [RL5]
    else $error("hold function and quad lines disagree");

  AST_RSVD_ZERO: assert property (rd_valid && rd_sel == `FSP_SEL_SR3
                                  |=> rd_data[1:0] == 2'h0 && rd_data[4:3] == 2'h0) // [RL17]
    else $error("reserved status bits read nonzero");

  AST_OP_SEQ: assert property (s_op_taken |=> s_op_done) // [RL18]
    else $error("operation not decided one cycle after start");

  AST_NONE_PROT: assert property ((state_q == fsp_eval) && !wps_q && !prot_q.cmp
                                  && prot_q.bp == 3'h0 |=> op_grant) // [RL12]
    else $error("operation refused with no protection");

  AST_ALL_PROT: assert property ((state_q == fsp_eval) && !wps_q && !prot_q.cmp
                                 && prot_q.bp == 3'h7 |=> op_deny) // [RL14]
    else $error("operation allowed with whole array protected");

  AST_LOCK_DENY: assert property ((state_q == fsp_eval) && wps_q && lock_q[0]
                                  && rs_w == 24'h000000 |=> op_deny) // [RL16]
    else $error("locked sector not refused");
endmodule : fsp_status_protect

// *** fsp_host_model.sv ***
`timescale 1ns/1ns
// ==========================================================
// Host side: drives requests after the falling edge, samples answers there
module fsp_host_model
  import fsp_pkg::*;
(
  input wire logic sys_clk,
  output logic instr_valid,
  output logic [7:0] instr_code,
  output logic sw_valid,
  output logic [1:0] sw_sel,
  output logic [7:0] sw_data,
  output logic rd_valid,
  output logic [1:0] rd_sel,
  input wire logic [7:0] rd_data,
  output logic op_valid,
  output fsp_op_t op_req,
  input wire logic op_busy,
  input wire logic op_grant,
  input wire logic op_deny,
  output logic secreg_valid,
  output logic [1:0] secreg_num,
  input wire logic secreg_grant,
  input wire logic secreg_deny,
  output logic blk_lock_valid,
  output logic blk_lock_set,
  output logic [23:0] blk_lock_addr
);
  // Busy sampled in the deciding cycle and on the answer cycle, where it has dropped
  logic [1:0] busy_seen;

  // Strobes low; qualifiers of idle strobes start as all ones, not a neat zero
  initial begin
    {instr_valid, sw_valid, rd_valid, op_valid, secreg_valid, blk_lock_valid} = 6'h00;
    {instr_code, sw_sel, sw_data, rd_sel, secreg_num, blk_lock_set, blk_lock_addr} = '1;
    op_req = '1;
  end

  // Status write; data goes as handed in, reserved bits included
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    @(negedge sys_clk);
    sw_valid = 1'b1;
    sw_sel = sel;
    sw_data = d;
    @(negedge sys_clk);
    sw_valid = 1'b0;
    sw_data = ~d;
  endtask : wr

  // Status read; the byte is registered, so it is taken one cycle on
  task automatic rd(input logic [1:0] sel, output logic [7:0] d);
    @(negedge sys_clk);
    rd_valid = 1'b1;
    rd_sel = sel;
    @(negedge sys_clk);
    rd_valid = 1'b0;
    rd_sel = ~sel;
    d = rd_data;
  endtask : rd

  task automatic ins(input logic [7:0] code);
    @(negedge sys_clk);
    instr_valid = 1'b1;
    instr_code = code;
    @(negedge sys_clk);
    instr_valid = 1'b0;
    instr_code = ~code;
  endtask : ins

  // Array request: take, deciding cycle, then one grant or deny pulse
  task automatic op(input fsp_kind_t k, input logic [23:0] a, output logic [1:0] r);
    @(negedge sys_clk);
    op_valid = 1'b1;
    op_req.kind = k;
    op_req.addr = a;
    @(negedge sys_clk);
    op_valid = 1'b0;
    op_req.addr = ~a;
    busy_seen[1] = op_busy;
    @(negedge sys_clk);
    r = {op_grant, op_deny};
    busy_seen[0] = op_busy;
  endtask : op

  task automatic sec(input logic [1:0] n, output logic [1:0] r);
    @(negedge sys_clk);
    secreg_valid = 1'b1;
    secreg_num = n;
    @(negedge sys_clk);
    secreg_valid = 1'b0;
    secreg_num = ~n;
    r = {secreg_grant, secreg_deny};
  endtask : sec

  task automatic lock(input logic set, input logic [23:0] a);
    @(negedge sys_clk);
    blk_lock_valid = 1'b1;
    blk_lock_set = set;
    blk_lock_addr = a;
    @(negedge sys_clk);
    blk_lock_valid = 1'b0;
    blk_lock_addr = ~a;
  endtask : lock
endmodule : fsp_host_model

// *** testbench.sv ***
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module testbench
  import fsp_pkg::*;
;
  localparam logic [1:0] G = 2'b10;
  localparam logic [1:0] D = 2'b01;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid, sw_valid, rd_valid, op_valid, secreg_valid, blk_lock_valid, blk_lock_set;
  logic [7:0] instr_code, sw_data, rd_data, v, e8;
  logic [1:0] sw_sel, rd_sel, secreg_num, output_strength, r;
  logic [23:0] blk_lock_addr;
  fsp_op_t op_req;
  logic op_busy, op_grant, op_deny, secreg_grant, secreg_deny;
  logic paused_op_flag, quad_lines_enable, hold_fn_enable, protect_scheme_select;
  int fails = 0;
  int comparisons = 0;

  fsp_status_protect dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_code(instr_code), .sw_valid(sw_valid), .sw_sel(sw_sel), .sw_data(sw_data),
    .rd_valid(rd_valid), .rd_sel(rd_sel), .rd_data(rd_data), .op_valid(op_valid),
    .op_req(op_req), .op_busy(op_busy), .op_grant(op_grant), .op_deny(op_deny),
    .secreg_valid(secreg_valid), .secreg_num(secreg_num), .secreg_grant(secreg_grant),
    .secreg_deny(secreg_deny), .blk_lock_valid(blk_lock_valid), .blk_lock_set(blk_lock_set),
    .blk_lock_addr(blk_lock_addr), .paused_op_flag(paused_op_flag),
    .quad_lines_enable(quad_lines_enable), .hold_fn_enable(hold_fn_enable),
    .protect_scheme_select(protect_scheme_select), .output_strength(output_strength));

  fsp_host_model host (.sys_clk(sys_clk), .instr_valid(instr_valid), .instr_code(instr_code),
    .sw_valid(sw_valid), .sw_sel(sw_sel), .sw_data(sw_data), .rd_valid(rd_valid),
    .rd_sel(rd_sel), .rd_data(rd_data), .op_valid(op_valid), .op_req(op_req),
    .op_busy(op_busy), .op_grant(op_grant), .op_deny(op_deny), .secreg_valid(secreg_valid),
    .secreg_num(secreg_num), .secreg_grant(secreg_grant), .secreg_deny(secreg_deny),
    .blk_lock_valid(blk_lock_valid), .blk_lock_set(blk_lock_set),
    .blk_lock_addr(blk_lock_addr));

  // ==========================================================
  // Clock, reset and closing
  always #5 sys_clk = ~sys_clk;

  task automatic rst();
    sys_rst = 1'b1;
    repeat (4) @(negedge sys_clk);
    sys_rst = 1'b0;
  endtask : rst

  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  // Status bits written just before the request, so the decision must use them
  task automatic pc(input logic [7:0] s1, input logic c, input fsp_kind_t k,
    input logic [23:0] a, input logic [1:0] e);
    host.wr(2'h1, s1);
    host.wr(2'h2, {1'b0, c, 6'h00});
    host.op(k, a, r);
    `CHK("op", e, r)
    `CHK("busy", 2'b10, host.busy_seen)
  endtask : pc

  // Runs well below a few thousand cycles, so the limit only cuts hangs
  initial begin
    #500000;
    fails++;
    end_sim();
  end

  // ==========================================================
  // Test sequence
  initial begin
    rst();
    host.rd(2'h2, v);
    `CHK("sr2", 8'h00, v)
    host.rd(2'h3, v);
    `CHK("sr3", 8'h00, v)
    `CHK("hold", 1'b1, hold_fn_enable)
    $display("test reset done");
    host.ins(8'h75);
    `CHK("paused", 1'b1, paused_op_flag)
    host.rd(2'h2, v);
    `CHK("sr2", 8'h80, v)
    host.ins(8'h7a);
    `CHK("paused", 1'b0, paused_op_flag)
    host.wr(2'h2, 8'h80);
    host.rd(2'h2, v);
    `CHK("sr2", 8'h00, v)
    host.ins(8'h75);
    rst();
    `CHK("paused", 1'b0, paused_op_flag)
    $display("test suspend done");
    for (int i = 0; i < 3; i++) begin
      host.wr(2'h2, 8'h08 << i);
      host.rd(2'h2, v);
      e8 = (8'h10 << i) - 8'h08;
      `CHK("otp", e8, v)
      for (int n = 1; n < 4; n++) begin
        host.sec(n[1:0], r);
        `CHK("secreg", (n <= i + 1) ? D : G, r)
      end
    end
    host.sec(2'h0, r);
    `CHK("secreg", D, r)
    host.wr(2'h2, 8'h07);
    `CHK("quad", 1'b1, quad_lines_enable)
    `CHK("hold", 1'b0, hold_fn_enable)
    host.rd(2'h2, v);
    `CHK("sr2", 8'h3a, v)
    host.wr(2'h2, 8'h00);
    `CHK("hold", 1'b1, hold_fn_enable)
    host.rd(2'h2, v);
    `CHK("sr2", 8'h38, v)
    $display("test otp quad done");
    for (int s = 0; s < 4; s++) begin
      host.wr(2'h3, {1'b0, s[1:0], 5'h00});
      `CHK("drive", s[1:0], output_strength)
    end
    host.wr(2'h3, 8'hff);
    host.rd(2'h3, v);
    `CHK("sr3", 8'h64, v)
    host.rd(2'h0, v);
    `CHK("sel0", 8'h00, v)
    $display("test config done");
    rst();
    pc(8'h04, 1'b0, fsp_k_b64, 24'hfc0000, D);
    pc(8'h04, 1'b0, fsp_k_b64, 24'hfb0000, G);
    pc(8'h04, 1'b0, fsp_k_page, 24'hfbff00, G);
    pc(8'h24, 1'b0, fsp_k_b64, 24'h030000, D);
    pc(8'h24, 1'b0, fsp_k_b64, 24'h040000, G);
    pc(8'h38, 1'b0, fsp_k_b64, 24'h7f0000, D);
    pc(8'h38, 1'b0, fsp_k_b64, 24'h800000, G);
    pc(8'h00, 1'b0, fsp_k_chip, 24'h000000, G);
    pc(8'h1c, 1'b0, fsp_k_page, 24'h000000, D);
    pc(8'h44, 1'b0, fsp_k_sec, 24'hfff000, D);
    pc(8'h44, 1'b0, fsp_k_sec, 24'hffe000, G);
    pc(8'h44, 1'b0, fsp_k_b64, 24'hff0000, D);
    pc(8'h48, 1'b0, fsp_k_sec, 24'hffd000, G);
    pc(8'h48, 1'b0, fsp_k_sec, 24'hffe000, D);
    pc(8'h6c, 1'b0, fsp_k_sec, 24'h003000, D);
    pc(8'h6c, 1'b0, fsp_k_sec, 24'h004000, G);
    pc(8'h70, 1'b0, fsp_k_sec, 24'h007000, D);
    pc(8'h74, 1'b0, fsp_k_sec, 24'h008000, G);
    pc(8'h74, 1'b0, fsp_k_b32, 24'h000000, D);
    pc(8'h04, 1'b1, fsp_k_b64, 24'hfc0000, G);
    pc(8'h04, 1'b1, fsp_k_b64, 24'hfb0000, D);
    pc(8'h00, 1'b1, fsp_k_page, 24'hffff00, D);
    $display("test protect range done");
    rst();
    host.wr(2'h3, 8'h04);
    `CHK("scheme", 1'b1, protect_scheme_select)
    pc(8'h00, 1'b0, fsp_k_sec, 24'h000000, D);
    host.lock(1'b0, 24'h000000);
    pc(8'h1c, 1'b0, fsp_k_sec, 24'h000000, G);
    pc(8'h00, 1'b0, fsp_k_sec, 24'h001000, D);
    host.lock(1'b0, 24'h100000);
    pc(8'h00, 1'b0, fsp_k_b64, 24'h100000, G);
    host.lock(1'b1, 24'h000000);
    pc(8'h00, 1'b0, fsp_k_sec, 24'h000000, D);
    host.wr(2'h3, 8'h00);
    pc(8'h00, 1'b0, fsp_k_sec, 24'h000000, G);
    $display("test lock scheme done");
    end_sim();
  end
endmodule : testbench
